// ==== pts_map.svh ====
// register offsets, field positions, reset values and timing figures of the start/stop block
`ifndef PTS_MAP_SVH
`define PTS_MAP_SVH
`define PTS_OFF_START    12'h000
`define PTS_OFF_STOP     12'h004
`define PTS_OFF_HIZEN    12'h008
`define PTS_OFF_CTRL     12'h00C
`define PTS_OFF_STATUS   12'h010
`define PTS_OFF_MASK     12'h014
`define PTS_OFF_OSCBND   12'h018
`define PTS_OFF_OSCMEAS  12'h01C
`define PTS_OFF_CNT0     12'h020
`define PTS_FLD_W        4
`define PTS_SEL_RST      16'hFFFF
`define PTS_HIZ01_LSB    0
`define PTS_HIZ23_LSB    8
`define PTS_HIZ_W        7
`define PTS_HIZ_MASK     16'h5F6F
`define PTS_ST_STOP_LSB  4
`define PTS_ST_OSC       8
`define PTS_ST_HIZ01     9
`define PTS_ST_HIZ23     10
`define PTS_ST_W         11
`define PTS_BND_HI_LSB   16
`define PTS_CLK_HZ       20000000
`define PTS_TCLK_DIV     4
`define PTS_WDT_DIV      8
`define PTS_OSCBND_RST   32'hFFFF_0000
`endif

// ==== pts_pkg.sv ====
// types shared by the start/stop source selection block
package pts_pkg;
  typedef struct packed {
    logic       etrg;
    logic       cmpB;
    logic       cmpA;
    logic       ioB;
    logic       ioA;
    logic [2:0] unit1Cmp;
    logic [2:0] unit0Cmp;
  } pts_src_s;
  typedef struct packed {
    logic in12;
    logic in11;
    logic in10;
    logic in8;
    logic in4;
    logic in0;
    logic shortFlag;
  } pts_flags_s;
endpackage

// ==== pts_hw_start_stop.sv ====
// hardware start/stop source selection, four counters, oscillation check and pair hi-z
// Function
// - The start register holds one 4-bit source field per counter at bits 0-3, 4-7, 8-11, 12-15.
// - The stop/clear register holds four 4-bit fields laid out like the start fields.
// - Codes 0, 1, 2 select comparator detection on channels 0-2 of the first converter unit.
// - Codes 4, 5, 6 select comparator detection on channels 0-2 of the second converter unit.
// - Codes 8 and 9 select the timer 3 A and B pin inputs.
// - Codes 10 and 11 select the timer 3 internal compare outputs A and B.
// - Code 12 selects the external trigger pin.
// - The oscillation check counts divided module clock ticks across divided watchdog edges.
// - Bits 0 and 8 enable the short flag as hi-z source for pairs 0/1 and 2/3.
// - For pair 0/1 bits 1,2,3,5,6 enable input flags 0,4,8,11,12; bit 4 is reserved.
// - For pair 2/3 bits 9-12 and 14 enable flags 0,4,8,10,12; bits 13 and 15 reserved.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
`include "pts_map.svh"
module pts_hw_start_stop #(
  parameter int CNT_W   = 16,
  parameter int TCLK_DIV = `PTS_TCLK_DIV,
  parameter int WDT_DIV  = `PTS_WDT_DIV
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire pts_pkg::pts_src_s     srcIn,
  input  wire pts_pkg::pts_flags_s   hizFlags,
  input  wire logic                  watchdogLowSpeedClock,
  output logic [3:0]                 counterRun,
  output logic [4*CNT_W-1:0]         pwmCounterValue,
  output logic [1:0]                 pairHiz,
  output logic                       irq
);
  // elaboration stops on sizes that the counters and the read mux cannot carry
  if (CNT_W < 1 || CNT_W > 32 || TCLK_DIV < 1 ||
      WDT_DIV < 1 || WDT_DIV > 255) begin : g_bad_param
    $error("pts_hw_start_stop: unsupported parameter values");
  end
  localparam int TDW = $clog2(TCLK_DIV + 1);

  // code -> event vector entry; codes 3, 7 and 13-15 pick nothing
  function automatic logic selEvent(input logic [3:0] code, input logic [15:0] ev);
    selEvent = ev[code];
  endfunction

  function automatic logic [15:0] rdMux(input logic [15:0] v);
    rdMux = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and edge detection
  logic [7:0] syncA_ff;
  logic [7:0] syncB_ff;
  logic [7:0] syncPrev_ff;
  logic [1:0] cmpPrev_ff;
  wire  [7:0] pinRaw = {srcIn.etrg, srcIn.ioB, srcIn.ioA, srcIn.unit1Cmp[2:0],
                        srcIn.unit0Cmp[1:0]};
  // unit0 channel 2 has its own three-stage chain, u02Sync_ff, with the same delay as the pin chain
  logic [2:0] u02Sync_ff;
  logic       wdA_ff;
  logic       wdB_ff;
  logic       wdPrev_ff;
  always_ff @(posedge mclk) begin
    syncA_ff    <= pinRaw;
    syncB_ff    <= syncA_ff;
    syncPrev_ff <= syncB_ff;
    u02Sync_ff  <= {u02Sync_ff[1:0], srcIn.unit0Cmp[2]};
    wdA_ff      <= watchdogLowSpeedClock;
    wdB_ff      <= wdA_ff;
    wdPrev_ff   <= wdB_ff;
    cmpPrev_ff  <= {srcIn.cmpB, srcIn.cmpA};
  end
  wire [7:0] pinRise = syncB_ff & ~syncPrev_ff;
  wire       u02Rise = u02Sync_ff[1] & ~u02Sync_ff[2];
  wire [1:0] cmpRise = {srcIn.cmpB, srcIn.cmpA} & ~cmpPrev_ff;
  wire       wdRise  = wdB_ff & ~wdPrev_ff;
  wire [15:0] evVec = {3'h0, pinRise[7], cmpRise[1], cmpRise[0], pinRise[6], pinRise[5],
                       1'b0, pinRise[4:2], 1'b0, u02Rise, pinRise[1:0]};

  ////////////////////////////////////////////////////////////////////////////
  // registers and apb slave
  logic [15:0]          startSel_ff;
  logic [15:0]          stopSel_ff;
  logic [15:0]          hizEn_ff;
  logic [3:0]           clrMode_ff;
  logic [`PTS_ST_W-1:0] status_ff;
  logic [`PTS_ST_W-1:0] mask_ff;
  logic [31:0]          oscBnd_ff;
  logic [15:0]          oscMeas_ff;
  logic [31:0]          prdata_ff;
  logic                 err_ff;
  logic [CNT_W-1:0]     cnt_ff [4];
  logic [3:0]           run_ff;

  wire setup  = psel & ~penable;
  wire wrAcc  = psel & penable & pwrite;
  wire wrStart = wrAcc & (paddr == `PTS_OFF_START);
  wire wrStop  = wrAcc & (paddr == `PTS_OFF_STOP);
  wire wrHiz   = wrAcc & (paddr == `PTS_OFF_HIZEN);
  wire wrCtrl  = wrAcc & (paddr == `PTS_OFF_CTRL);
  wire wrStat  = wrAcc & (paddr == `PTS_OFF_STATUS);
  wire wrMask  = wrAcc & (paddr == `PTS_OFF_MASK);
  wire wrBnd   = wrAcc & (paddr == `PTS_OFF_OSCBND);
  wire isCnt   = (paddr[11:4] == 8'(`PTS_OFF_CNT0 >> 4)) & (paddr[1:0] == 2'h0);
  logic [31:0] rdVal;
  logic        rdHit;
  always_comb begin
    rdHit = 1'b1;
    rdVal = 32'h0;
    unique case (paddr)
      `PTS_OFF_START:   rdVal = {16'h0, rdMux(startSel_ff)};
      `PTS_OFF_STOP:    rdVal = {16'h0, rdMux(stopSel_ff)};
      `PTS_OFF_HIZEN:   rdVal = {16'h0, rdMux(hizEn_ff)};
      `PTS_OFF_CTRL:    rdVal = {28'h0, clrMode_ff};
      `PTS_OFF_STATUS:  rdVal = {{(32-`PTS_ST_W){1'b0}}, status_ff};
      `PTS_OFF_MASK:    rdVal = {{(32-`PTS_ST_W){1'b0}}, mask_ff};
      `PTS_OFF_OSCBND:  rdVal = oscBnd_ff;
      `PTS_OFF_OSCMEAS: rdVal = {16'h0, oscMeas_ff};
      default: begin
        rdHit = isCnt;
        rdVal = isCnt ? 32'(cnt_ff[paddr[3:2]]) : 32'h0;
      end
    endcase
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_ff <= 32'h0;
      err_ff    <= 1'b0;
    end else if (setup) begin
      prdata_ff <= pwrite ? 32'h0 : rdVal;
      // counters are read-only: a write there is refused
      err_ff    <= ~rdHit | (pwrite & isCnt) | (pwrite & (paddr == `PTS_OFF_OSCMEAS));
    end
  end
  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = psel & penable & err_ff;
  wire okWr = ~err_ff;

  // reset leaves every field on an unused code so no counter starts on its own
  always_ff @(posedge mclk) begin
    if (rst) begin
      startSel_ff <= `PTS_SEL_RST;
      stopSel_ff  <= `PTS_SEL_RST;
      hizEn_ff    <= 16'h0;
      clrMode_ff  <= 4'h0;
      mask_ff     <= '0;
      oscBnd_ff   <= `PTS_OSCBND_RST;
    end else if (okWr) begin
      if (wrStart) startSel_ff <= pwdata[15:0];
      if (wrStop)  stopSel_ff  <= pwdata[15:0];
      if (wrHiz)   hizEn_ff    <= pwdata[15:0] & `PTS_HIZ_MASK;
      if (wrCtrl)  clrMode_ff  <= pwdata[3:0];
      if (wrMask)  mask_ff     <= pwdata[`PTS_ST_W-1:0];
      if (wrBnd)   oscBnd_ff   <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters: stop wins over start in the same cycle
  logic [3:0] startEv;
  logic [3:0] stopEv;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      startEv[i] = selEvent(startSel_ff[i*`PTS_FLD_W +: `PTS_FLD_W], evVec);
      stopEv[i]  = selEvent(stopSel_ff[i*`PTS_FLD_W +: `PTS_FLD_W], evVec);
    end
  end
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (rst) begin
        run_ff[i] <= 1'b0;
        cnt_ff[i] <= '0;
      end else begin
        if (stopEv[i]) run_ff[i] <= 1'b0;
        else if (startEv[i]) run_ff[i] <= 1'b1;
        if (stopEv[i] && clrMode_ff[i]) cnt_ff[i] <= '0;
        else if (run_ff[i]) cnt_ff[i] <= cnt_ff[i] + 1'b1;
      end
    end
  end
  assign counterRun = run_ff;
  always_comb begin
    for (int i = 0; i < 4; i++) pwmCounterValue[i*CNT_W +: CNT_W] = cnt_ff[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillation check: ticks of the divided module clock per WDT_DIV watchdog edges
  logic [TDW-1:0] tDiv_ff;
  logic [7:0]     wdCnt_ff;
  logic [15:0]    meas_ff;
  logic           oscBad;
  wire tick    = (tDiv_ff == TDW'(TCLK_DIV - 1));
  wire wdDone  = wdRise & (wdCnt_ff == 8'(WDT_DIV - 1));
  always_ff @(posedge mclk) begin
    if (rst) begin
      tDiv_ff    <= '0;
      wdCnt_ff   <= 8'h0;
      meas_ff    <= 16'h0;
      oscMeas_ff <= 16'h0;
    end else begin
      tDiv_ff <= tick ? '0 : tDiv_ff + 1'b1;
      if (wdRise) wdCnt_ff <= wdDone ? 8'h0 : wdCnt_ff + 1'b1;
      if (wdDone) begin
        oscMeas_ff <= meas_ff;
        meas_ff    <= 16'h0;
      end else if (tick && meas_ff != 16'hFFFF) meas_ff <= meas_ff + 1'b1;
    end
  end
  // saturation at full scale means the watchdog clock has stopped
  assign oscBad = (wdDone && (meas_ff < oscBnd_ff[15:0] ||
                   meas_ff > oscBnd_ff[`PTS_BND_HI_LSB +: 16])) || (tick && meas_ff == 16'hFFFE);

  ////////////////////////////////////////////////////////////////////////////
  // pair high impedance
  wire [6:0] flags01 = {hizFlags.in12, hizFlags.in11, 1'b0, hizFlags.in8, hizFlags.in4,
                        hizFlags.in0, hizFlags.shortFlag};
  wire [6:0] flags23 = {hizFlags.in12, 1'b0, hizFlags.in10, hizFlags.in8, hizFlags.in4,
                        hizFlags.in0, hizFlags.shortFlag};
  logic [1:0] hiz_ff;
  wire [1:0] nxt_hiz = {|(hizEn_ff[`PTS_HIZ23_LSB +: `PTS_HIZ_W] & flags23),
                        |(hizEn_ff[`PTS_HIZ01_LSB +: `PTS_HIZ_W] & flags01)};
  always_ff @(posedge mclk) begin
    if (rst) hiz_ff <= 2'h0;
    else hiz_ff <= nxt_hiz;
  end
  assign pairHiz = hiz_ff;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: set wins over a write-one clear
  wire [`PTS_ST_W-1:0] stSet = {nxt_hiz & ~hiz_ff, oscBad, stopEv, startEv};
  wire [`PTS_ST_W-1:0] stClr = (wrStat & okWr) ? pwdata[`PTS_ST_W-1:0] : '0;
  always_ff @(posedge mclk) begin
    if (rst) status_ff <= '0;
    else status_ff <= (status_ff & ~stClr) | stSet;
  end
  assign irq = |(status_ff & mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_start_cnt0; startEv[0] && !stopEv[0] |=> counterRun[0]; endproperty
  a_start_cnt0: assert property (p_start_cnt0) else $error("start event ignored");
  property p_stop_clear; stopEv[0] && clrMode_ff[0] |=> !counterRun[0] && cnt_ff[0] == '0;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear");
  property p_pin_a;
    startSel_ff[3:0] == 4'h8 && !stopEv[0] && $rose(syncB_ff[5]) |=> counterRun[0];
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin A did not start counter 0");
  property p_etrg;
    stopSel_ff[3:0] == 4'hC && $rose(syncB_ff[7]) |=> !counterRun[0];
  endproperty
  a_etrg: assert property (p_etrg) else $error("trigger pin did not stop counter 0");
  property p_cmp_b; startSel_ff[3:0] == 4'hB && $rose(srcIn.cmpB) |-> startEv[0]; endproperty
  a_cmp_b: assert property (p_cmp_b) else $error("compare B not selected");
  property p_unit1; stopSel_ff[3:0] == 4'h5 && $rose(syncB_ff[3]) |-> stopEv[0]; endproperty
  a_unit1: assert property (p_unit1) else $error("unit1 channel1 not selected");
  property p_unit0; startSel_ff[3:0] == 4'h1 && $rose(syncB_ff[1]) |-> startEv[0]; endproperty
  a_unit0: assert property (p_unit0) else $error("unit0 channel1 not selected");
  property p_hiz01; hizEn_ff[0] && hizFlags.shortFlag |=> pairHiz[0]; endproperty
  a_hiz01: assert property (p_hiz01) else $error("pair 0/1 not hi-z");
  property p_hiz23; hizEn_ff[14] && hizFlags.in12 |=> pairHiz[1]; endproperty
  a_hiz23: assert property (p_hiz23) else $error("pair 2/3 not hi-z");
  // pair 0/1 cause built from the enable bits one by one; bit 4 takes part in nothing
  wire cause01 = (hizEn_ff[0] & hizFlags.shortFlag) | (hizEn_ff[1] & hizFlags.in0) |
                 (hizEn_ff[2] & hizFlags.in4) | (hizEn_ff[3] & hizFlags.in8) |
                 (hizEn_ff[5] & hizFlags.in11) | (hizEn_ff[6] & hizFlags.in12);
  property p_rsvd; pairHiz[0] |-> $past(cause01); endproperty
  a_rsvd: assert property (p_rsvd) else $error("pair 0/1 hi-z without cause");
  property p_osc; wdDone |=> oscMeas_ff == $past(meas_ff) && meas_ff == 16'h0; endproperty
  a_osc: assert property (p_osc) else $error("measurement not captured");
  property p_wr_start; okWr && wrStart |=> startSel_ff == $past(pwdata[15:0]); endproperty
  a_wr_start: assert property (p_wr_start) else $error("start select not written");
  // an idle bus here means no clear or mask write can land in the next two cycles
  property p_irq; stSet[8] && mask_ff[8] && !psel |=> irq[*2]; endproperty
  a_irq: assert property (p_irq) else $error("anomaly interrupt missing");
  property p_io_b;
    startSel_ff[3:0] == 4'h9 && !stopEv[0] && $rose(syncB_ff[6]) |=> counterRun[0];
  endproperty
  a_io_b: assert property (p_io_b) else $error("pin B did not start counter 0");
  property p_unit0_ch2; startSel_ff[3:0] == 4'h2 && $rose(u02Sync_ff[1]) |-> startEv[0];
  endproperty
  a_unit0_ch2: assert property (p_unit0_ch2) else $error("unit0 channel2 not selected");
  property p_no_code;
    startSel_ff[3:0] inside {4'h3, 4'h7, 4'hD, 4'hE, 4'hF} |-> !startEv[0];
  endproperty
  a_no_code: assert property (p_no_code) else $error("unused code started counter 0");
  property p_stop_wins; stopEv[2] |=> !counterRun[2]; endproperty
  a_stop_wins: assert property (p_stop_wins) else $error("stop event ignored");
  property p_hiz_in10; hizEn_ff[12] && hizFlags.in10 |=> pairHiz[1]; endproperty
  a_hiz_in10: assert property (p_hiz_in10) else $error("pair 2/3 ignored input 10");
  property p_hiz_in11; hizEn_ff[5] && hizFlags.in11 |=> pairHiz[0]; endproperty
  a_hiz_in11: assert property (p_hiz_in11) else $error("pair 0/1 ignored input 11");
  property p_hiz_idle; hizFlags == '0 |=> pairHiz == 2'h0; endproperty
  a_hiz_idle: assert property (p_hiz_idle) else $error("hi-z without any flag");
  c_start: cover property (startEv[0] ##[1:20] stopEv[0]);
  c_hiz: cover property ($rose(pairHiz[1]));
  c_osc: cover property (wdDone && oscBad);
  c_clear: cover property (stopEv[0] && clrMode_ff[0]);
  c_irq: cover property ($rose(irq));
endmodule // pts_hw_start_stop

// ==== pts_src_model.sv ====
// behavioural model of comparators, timer 3 pins and compare outputs, trigger pin
`timescale 1ns/100ps
module pts_src_model (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         fire,
  input  wire logic [3:0]   fireBit,
  output pts_pkg::pts_src_s srcIn
);
  logic [2:0] holdCnt_ff;
  // pulse is held several clocks so the two-stage pin synchroniser cannot miss it
  always_ff @(posedge mclk) begin
    if (rst) begin
      holdCnt_ff <= 3'h0;
      srcIn      <= '0;
    end else if (fire) begin
      holdCnt_ff <= 3'h4;
      srcIn      <= pts_pkg::pts_src_s'(11'h001 << fireBit);
    end else if (holdCnt_ff != 3'h0) begin
      holdCnt_ff <= holdCnt_ff - 3'h1;
    end else begin
      srcIn <= '0;
    end
  end
endmodule // pts_src_model

// ==== pts_hw_start_stop_tb.sv ====
// self-checking bench of the start/stop source selection block
`timescale 1ns/100ps
`include "pts_map.svh"
module pts_hw_start_stop_tb;
  logic                 mclk = 1'b0;
  logic                 rst = 1'b1;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0;
  logic                 pready;
  logic [31:0]          prdata;
  logic                 pslverr;
  pts_pkg::pts_src_s    srcIn;
  pts_pkg::pts_flags_s  hizFlags = '0;
  logic                 wdClk = 1'b0;
  logic [3:0]           counterRun;
  logic [63:0]          pwmCounterValue;
  logic [1:0]           pairHiz;
  logic                 irq;
  logic                 fire = 1'b0;
  logic [3:0]           fireBit = 4'h0;
  logic [31:0]          q;
  logic                 e;
  int                   errorCnt = 0;
  int                   checkCount = 0;
  // source code of each source bit, in the packed order of the source struct;
  // codes 3 and 7 are never written by any scenario
  logic [3:0]           codeTab [11] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6,
                                         4'h8, 4'h9, 4'hA, 4'hB, 4'hC};

  always #25 mclk = ~mclk;
  // free-running slow clock, unrelated in phase: 20 module clocks a period
  always #500.3 wdClk = ~wdClk;

  pts_hw_start_stop #(.CNT_W(16), .TCLK_DIV(4), .WDT_DIV(8)) i_pts_hw_start_stop (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .srcIn(srcIn), .hizFlags(hizFlags),
    .watchdogLowSpeedClock(wdClk), .counterRun(counterRun),
    .pwmCounterValue(pwmCounterValue), .pairHiz(pairHiz), .irq(irq));

  pts_src_model i_pts_src_model (.mclk(mclk), .rst(rst), .fire(fire), .fireBit(fireBit),
    .srcIn(srcIn));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic reportAndStop;
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // field i of a select word set to code c, all other fields select nothing
  function automatic logic [31:0] fld(input int i, input logic [3:0] c);
    return {16'h0, (16'hFFFF & ~(16'hF << 4*i)) | (16'(c) << 4*i)};
  endfunction

  task automatic pulse(input logic [3:0] b);
    @(posedge mclk);
    fire    <= 1'b1;
    fireBit <= b;
    @(posedge mclk);
    fire    <= 1'b0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2_000_000;
    errorCnt++;
    reportAndStop();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk({counterRun, pairHiz, irq}, 32'h0);
    apb(1'b0, `PTS_OFF_START, 32'h0);
    chk(q, 32'hFFFF);
    apb(1'b0, `PTS_OFF_STOP, 32'h0);
    chk(q, 32'hFFFF);
    apb(1'b0, `PTS_OFF_OSCBND, 32'h0);
    chk(q, `PTS_OSCBND_RST);
    for (int k = 0; k < 11; k++) begin
      apb(1'b1, `PTS_OFF_STOP, 32'hFFFF);
      apb(1'b1, `PTS_OFF_START, fld(0, codeTab[k]));
      pulse(4'((k + 1) % 11));
      chk(counterRun, 32'h0);
      pulse(4'(k));
      chk(counterRun, 32'h1);
      apb(1'b1, `PTS_OFF_START, 32'hFFFF);
      apb(1'b1, `PTS_OFF_STOP, fld(0, codeTab[k]));
      pulse(4'(k));
      chk(counterRun, 32'h0);
    end
    apb(1'b1, `PTS_OFF_STOP, 32'hFFFF);
    // codes 13 to 15 must start nothing, whatever source fires
    for (int c = 13; c < 16; c++) begin
      apb(1'b1, `PTS_OFF_START, fld(0, 4'(c)));
      for (int b = 0; b < 11; b++) pulse(4'(b));
      chk(counterRun, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `PTS_OFF_START, fld(i, 4'hA));
      pulse(4'h8);
      chk(counterRun, (32'h1 << (i + 1)) - 32'h1);
    end
    apb(1'b1, `PTS_OFF_START, 32'hFFFF);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `PTS_OFF_STOP, fld(i, 4'h8));
      pulse(4'h6);
      chk(counterRun, (32'hF << (i + 1)) & 32'hF);
    end
    apb(1'b1, `PTS_OFF_STATUS, 32'h7FF);
    apb(1'b1, `PTS_OFF_MASK, 32'h0);
    apb(1'b1, `PTS_OFF_STOP, 32'hFFFF);
    apb(1'b1, `PTS_OFF_START, fld(0, 4'hA));
    pulse(4'h8);
    chk(irq, 32'h0);
    apb(1'b0, `PTS_OFF_STATUS, 32'h0);
    chk(q & 32'h1, 32'h1);
    apb(1'b1, `PTS_OFF_MASK, 32'h1);
    @(negedge mclk);
    chk(irq, 32'h1);
    apb(1'b1, `PTS_OFF_STATUS, 32'h1);
    @(negedge mclk);
    chk(irq, 32'h0);
    // clear mode: the stop event must also zero the count
    apb(1'b1, `PTS_OFF_CTRL, 32'h1);
    apb(1'b1, `PTS_OFF_STOP, fld(0, 4'h8));
    apb(1'b0, `PTS_OFF_CNT0, 32'h0);
    chk(q != 32'h0, 32'h1);
    pulse(4'h6);
    apb(1'b0, `PTS_OFF_CNT0, 32'h0);
    chk({q[30:0], counterRun[0]}, 32'h0);
    chk(pwmCounterValue[15:0], 32'h0);
    apb(1'b1, `PTS_OFF_HIZEN, 32'hFFFF);
    apb(1'b0, `PTS_OFF_HIZEN, 32'h0);
    chk(q, 32'h5F6F);
    for (int j = 0; j < 7; j++) begin
      @(posedge mclk);
      hizFlags <= pts_pkg::pts_flags_s'(7'h01 << j);
      repeat (3) @(negedge mclk);
      chk(pairHiz, {30'h0, j != 5, j != 4});
      @(posedge mclk);
      hizFlags <= '0;
      repeat (3) @(negedge mclk);
      chk(pairHiz, 32'h0);
    end
    apb(1'b1, `PTS_OFF_HIZEN, 32'h0);
    hizFlags <= '1;
    repeat (3) @(negedge mclk);
    chk(pairHiz, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(e, 32'h1);
    apb(1'b1, `PTS_OFF_CNT0, 32'h5);
    chk(e, 32'h1);
    apb(1'b1, `PTS_OFF_STATUS, 32'h7FF);
    repeat (400) @(posedge mclk);
    apb(1'b0, `PTS_OFF_OSCMEAS, 32'h0);
    chk(q >= 32'd32 && q <= 32'd48, 32'h1);
    apb(1'b0, `PTS_OFF_STATUS, 32'h0);
    chk(q[8], 32'h0);
    apb(1'b1, `PTS_OFF_MASK, 32'h100);
    apb(1'b1, `PTS_OFF_OSCBND, 32'h0010_0000);
    repeat (400) @(posedge mclk);
    apb(1'b0, `PTS_OFF_STATUS, 32'h0);
    chk(q[8], 32'h1);
    chk(irq, 32'h1);
    reportAndStop();
  end
endmodule // pts_hw_start_stop_tb
